// ==== clk_ctl_consts.svh ====
// offsets, bit positions, reset values and tables of the control bank
`ifndef CLK_CTL_CONSTS_SVH
`define CLK_CTL_CONSTS_SVH
// byte offsets and pointer limits
`define OFS_FIRST 7'h01
`define OFS_LAST 7'h09
`define OFS_HOST_CTL 7'h01
`define OFS_SIGNATURE 7'h06
`define PTR_ZERO 7'h00
`define PTR_MAX 7'h7F
`define PTR_STEP 7'h01
// command byte: bit 7 set means single-byte access
`define CMD_SINGLE 7
// array indices of the bytes
`define IDX_B1 4'h1
`define IDX_B2 4'h2
`define IDX_B3 4'h3
`define IDX_B4 4'h4
`define IDX_B5 4'h5
`define IDX_B7 4'h7
`define IDX_B8 4'h8
`define IDX_B9 4'h9
`define NUM_REG_BYTES 10
// per-byte reset values and write masks, byte 9 in the top lane
`define REG_RESET_TABLE 80'h0000_0E00_403F_C77F_0700
`define REG_WMASK_TABLE 80'hFFFF_0100_C5BF_FFFF_7F00
`define BYTE_W 8
`define LANE_PAD 3'h0
// field positions
`define B1_HIZ_SEL 6
`define B1_FREE_LSB 3
`define B1_EN_LSB 0
`define B2_REF_LOW 7
`define B3_DOT_EN 7
`define B3_USB_EN 6
`define B3_FSTOP_LSB 3
`define B3_FEN_LSB 0
`define B4_SS_MSB 7
`define B5_SS_MID 7
`define B5_SS_LSB 6
`define B5_DOT_SLOW 2
`define B5_USB_SLOW 0
`define B7_NUM_MSB 0
`define B9_DIV_LSB 1
`define B9_SRC 0
// spread in hundredths of a percent, code 7 in the top lane
`define SPREAD_DN_TABLE 64'h9625_190D_644B_3219
`define SPREAD_UP_TABLE 64'h3225_190D_0000_0000
// misc values
`define RD_UNMAPPED 8'h00
`define SYNC_RST 4'hE
`define ALL_RUN 8'hFF
`endif

// ==== clk_ctl_pkg.sv ====
// types shared by the control bank
`default_nettype none
package clk_ctl_pkg;
    typedef enum logic [1:0] {HP_RUN, HP_PARK, HP_HIZ} host_pair_e;
endpackage
`default_nettype wire

// ==== clock_synth_control_regs.sv ====
// control and status byte bank, bytes 1 to 9, of the clock synthesizer
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctl_consts.svh"

// Summary of operation
// - byte 1 bit 7 reads the synchronised multiplier select pin; writes ignored
// - byte 1 bit 6 picks park or three-state for stopped host pairs
// - with byte 1 bit 6 set, power-down three-states all host pairs
// - byte 1 bits 5..3 keep pairs 2..0 running during host stop
// - byte 1 bits 2..0 enable host pairs 2..0, else three-state
// - byte 2 bit 7 selects low reference drive strength
// - byte 2 bits 6..0 enable the seven PCI outputs, else held low
// - byte 3 bits 7 and 6 enable the display and serial-bus 48 MHz outputs
// - byte 3 bits 5..3 make free PCI outputs obey the PCI stop pin
// - byte 3 bits 2..0 enable free PCI outputs, else held low
// - byte 4 bit 7 is spread select msb: down or center spread
// - byte 4 bits 5..0 enable the six 66 MHz outputs; bit 6 reserved
// - byte 5 bits 7 and 6 are spread mid and lsb, reset 0 and 1
// - spread code maps to four down and four center spread amounts
// - byte 5 bit 2 slows the display 48 MHz edge
// - byte 5 bit 0 slows the serial-bus 48 MHz edge
// - byte 6 reads fixed revision and vendor codes
// - nine-bit numerator in bytes 7 and 8, seven-bit divider in byte 9
// - byte 9 bit 0 selects ROM or programmed numerator and divider
// - byte 0 power-down mode bit selects park or three-state at power-down
// - command bit 7 picks block or single-byte access; low bits give single-byte offset, block starts at byte 0 and needs them 0
module clock_synth_control_regs
    import clk_ctl_pkg::*;
#(
    parameter logic [3:0] REVISION_ID = 4'h3, // arbitrary value
    parameter logic [3:0] VENDOR_ID = 4'h5, // arbitrary value
    parameter logic [8:0] ROM_NUMERATOR = 9'h000,
    parameter logic [6:0] ROM_DIVIDER = 7'h00
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // asynchronous control pins
    input wire logic i_host_clock_stop_n,
    input wire logic i_power_down_n,
    input wire logic i_pci_clock_stop_n,
    input wire logic i_current_multiplier_select,
    // power-down mode bit held by the byte 0 bank
    input wire logic i_pd_mode_three_state,
    // output clock boundary ticks
    input wire logic i_host_edge,
    input wire logic i_periph_edge,
    // byte access port from the management protocol engine
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd_req,
    output var logic [7:0] o_rdata,
    output var logic o_rd_valid,
    // host clock pairs
    output var host_pair_e o_host_pair_mode_0,
    output var host_pair_e o_host_pair_mode_1,
    output var host_pair_e o_host_pair_mode_2,
    // peripheral clock gates
    output var logic [6:0] o_pci_run,
    output var logic [2:0] o_free_pci_run,
    output var logic o_display_48m_run,
    output var logic o_serial_bus_48m_run,
    output var logic [5:0] o_fixed_66m_run,
    // drive and edge controls
    output var logic o_ref_low_strength,
    output var logic o_display_48m_slow_edge,
    output var logic o_serial_bus_48m_slow_edge,
    // spread control
    output var logic [2:0] o_spread_sel,
    output var logic o_spread_center,
    output var logic [7:0] o_spread_up,
    output var logic [7:0] o_spread_down,
    // synthesizer ratio
    output var logic [8:0] o_numerator,
    output var logic [6:0] o_divider
);
    // lookup tables given names so that they can be sliced
    localparam RESET_TAB = `REG_RESET_TABLE;
    localparam WMASK_TAB = `REG_WMASK_TABLE;
    localparam SPREAD_UP_TAB = `SPREAD_UP_TABLE;
    localparam SPREAD_DN_TAB = `SPREAD_DN_TABLE;
    logic [7:0] regs [0:`NUM_REG_BYTES-1];
    logic [3:0] pins_s;
    logic stop_s, pd_s, pcistop_s, mult_s;
    logic [6:0] ptr;
    logic blk, bad, hit;
    logic [3:0] idx;
    logic [7:0] wmask;
    logic [7:0] next_rdata;
    logic [1:0] run_48m;
    logic [2:0] spread_code;
    logic [6:0] pci_want;
    logic [2:0] free_want;
    logic [5:0] fixed_want;
    logic hiz_sel;

    // pin levels into the clock domain
    cs_sync2 #(
        .W(4),
        .RST(`SYNC_RST)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_host_clock_stop_n, i_power_down_n, i_pci_clock_stop_n,
            i_current_multiplier_select}),
        .o_q(pins_s)
    );
    assign stop_s = pins_s[3];
    assign pd_s = pins_s[2];
    assign pcistop_s = pins_s[1];
    assign mult_s = pins_s[0];

    // command byte sets up the access pointer
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ptr <= `PTR_ZERO;
            blk <= 1'b0;
            bad <= 1'b0;
        end
        else if (i_cmd_valid)
        begin
            ptr <= i_cmd[`CMD_SINGLE] ? i_cmd[6:0] : `PTR_ZERO;
            blk <= !i_cmd[`CMD_SINGLE];
            bad <= !i_cmd[`CMD_SINGLE] && (i_cmd[6:0] != `PTR_ZERO);
        end
        else if ((i_wr_valid || i_rd_req) && blk && (ptr != `PTR_MAX))
        begin
            ptr <= ptr + `PTR_STEP; // block access walks the bytes
        end
    end

    // address decode and per-byte write mask
    assign hit = !bad && (ptr >= `OFS_FIRST) && (ptr <= `OFS_LAST);
    assign idx = ptr[3:0];
    assign wmask = WMASK_TAB[{idx, `LANE_PAD} +: `BYTE_W];

    // register storage; masked bits keep their power-up values
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < `NUM_REG_BYTES; i++)
                regs[i] <= RESET_TAB[i*`BYTE_W +: `BYTE_W];
        end
        else if (i_wr_valid && hit)
        begin
            regs[idx] <= (regs[idx] & ~wmask) | (i_wdata & wmask);
        end
    end

    // read data selection
    always_comb
    begin
        if (!hit)
            next_rdata = `RD_UNMAPPED;
        else if (ptr == `OFS_HOST_CTL)
            next_rdata = {mult_s, regs[`IDX_B1][6:0]};
        else if (ptr == `OFS_SIGNATURE)
            next_rdata = {REVISION_ID, VENDOR_ID};
        else
            next_rdata = regs[idx];
    end

    // read answer one cycle after the request
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rdata <= `RD_UNMAPPED;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_req;
            if (i_rd_req)
                o_rdata <= next_rdata;
        end
    end

    // host pair mode from enable, free-run and stop conditions
    assign hiz_sel = regs[`IDX_B1][`B1_HIZ_SEL];
    function automatic host_pair_e host_mode(input logic en, input logic free);
        host_pair_e m;
        m = HP_RUN;
        if (!en)
            m = HP_HIZ;
        else if (!pd_s)
            m = (hiz_sel || i_pd_mode_three_state) ? HP_HIZ : HP_PARK;
        else if (!stop_s && !free)
            m = hiz_sel ? HP_HIZ : HP_PARK;
        return m;
    endfunction

    // host pairs change state only at a host clock boundary
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_host_pair_mode_0 <= HP_RUN;
            o_host_pair_mode_1 <= HP_RUN;
            o_host_pair_mode_2 <= HP_RUN;
        end
        else if (i_host_edge)
        begin
            o_host_pair_mode_0 <= host_mode(regs[`IDX_B1][`B1_EN_LSB],
                regs[`IDX_B1][`B1_FREE_LSB]);
            o_host_pair_mode_1 <= host_mode(regs[`IDX_B1][`B1_EN_LSB+1],
                regs[`IDX_B1][`B1_FREE_LSB+1]);
            o_host_pair_mode_2 <= host_mode(regs[`IDX_B1][`B1_EN_LSB+2],
                regs[`IDX_B1][`B1_FREE_LSB+2]);
        end
    end

    // requested run states of the peripheral outputs
    assign pci_want = regs[`IDX_B2][6:0] & {7{pcistop_s}};
    assign free_want = regs[`IDX_B3][`B3_FEN_LSB +: 3]
        & ~(regs[`IDX_B3][`B3_FSTOP_LSB +: 3] & {3{!pcistop_s}});
    assign fixed_want = {regs[`IDX_B4][3:0], regs[`IDX_B4][4], regs[`IDX_B4][5]};

    // boundary gates for each output group
    cs_edge_gate #(
        .W(7),
        .RST(7'(`ALL_RUN))
    ) u_pci_gate (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_boundary(i_periph_edge),
        .i_want(pci_want),
        .o_run(o_pci_run)
    );
    cs_edge_gate #(
        .W(3),
        .RST(3'(`ALL_RUN))
    ) u_free_gate (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_boundary(i_periph_edge),
        .i_want(free_want),
        .o_run(o_free_pci_run)
    );
    cs_edge_gate #(
        .W(2),
        .RST(2'(`ALL_RUN))
    ) u_48m_gate (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_boundary(i_periph_edge),
        .i_want({regs[`IDX_B3][`B3_DOT_EN], regs[`IDX_B3][`B3_USB_EN]}),
        .o_run(run_48m)
    );
    cs_edge_gate #(
        .W(6),
        .RST(6'(`ALL_RUN))
    ) u_66m_gate (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_boundary(i_periph_edge),
        .i_want(fixed_want),
        .o_run(o_fixed_66m_run)
    );
    assign o_display_48m_run = run_48m[1];
    assign o_serial_bus_48m_run = run_48m[0];

    // plain configuration bits straight from the bank
    assign o_ref_low_strength = regs[`IDX_B2][`B2_REF_LOW];
    assign o_display_48m_slow_edge = regs[`IDX_B5][`B5_DOT_SLOW];
    assign o_serial_bus_48m_slow_edge = regs[`IDX_B5][`B5_USB_SLOW];
    assign spread_code = {regs[`IDX_B4][`B4_SS_MSB], regs[`IDX_B5][`B5_SS_MID],
        regs[`IDX_B5][`B5_SS_LSB]};
    assign o_spread_sel = spread_code;
    assign o_spread_center = regs[`IDX_B4][`B4_SS_MSB];

    // spread amount lookup, registered
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_spread_up <= `RD_UNMAPPED;
            o_spread_down <= `RD_UNMAPPED;
        end
        else
        begin
            o_spread_up <= SPREAD_UP_TAB[{spread_code, `LANE_PAD} +: `BYTE_W];
            o_spread_down <= SPREAD_DN_TAB[{spread_code, `LANE_PAD} +: `BYTE_W];
        end
    end

    // ratio source mux, registered
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_numerator <= ROM_NUMERATOR;
            o_divider <= ROM_DIVIDER;
        end
        else if (regs[`IDX_B9][`B9_SRC])
        begin
            o_numerator <= {regs[`IDX_B7][`B7_NUM_MSB], regs[`IDX_B8]};
            o_divider <= regs[`IDX_B9][7:`B9_DIV_LSB];
        end
        else
        begin
            o_numerator <= ROM_NUMERATOR;
            o_divider <= ROM_DIVIDER;
        end
    end

    // checks on the bank behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_mult_readback:
    assert property ((i_rd_req && hit && ptr == `OFS_HOST_CTL)
        |=> o_rd_valid && o_rdata[7] == $past(mult_s))
    else $error("multiplier select readback wrong");

    a_pd_three_state:
    assert property ((i_host_edge && !pd_s && hiz_sel) |=> o_host_pair_mode_0 == HP_HIZ
        && o_host_pair_mode_1 == HP_HIZ && o_host_pair_mode_2 == HP_HIZ)
    else $error("host pairs not three-stated at power-down");

    a_stop_park:
    assert property ((i_host_edge && pd_s && !stop_s && !hiz_sel
        && regs[`IDX_B1][`B1_EN_LSB] && !regs[`IDX_B1][`B1_FREE_LSB])
        |=> o_host_pair_mode_0 == HP_PARK)
    else $error("stoppable host pair not parked");

    a_free_running:
    assert property ((i_host_edge && pd_s && regs[`IDX_B1][`B1_EN_LSB+2]
        && regs[`IDX_B1][`B1_FREE_LSB+2]) |=> o_host_pair_mode_2 == HP_RUN)
    else $error("free running host pair stopped");

    a_host_disable:
    assert property ((i_host_edge && !regs[`IDX_B1][`B1_EN_LSB+1])
        |=> o_host_pair_mode_1 == HP_HIZ)
    else $error("disabled host pair still driving");

    a_free_pci_stop:
    assert property ((i_periph_edge && regs[`IDX_B3][`B3_FSTOP_LSB] && !pcistop_s)
        |=> !o_free_pci_run[0])
    else $error("stoppable free pci output kept running");

    a_pci_enable:
    assert property ((i_periph_edge && pcistop_s) |=> o_pci_run == $past(regs[`IDX_B2][6:0]))
    else $error("pci run state does not follow enables");

    a_66m_order:
    assert property (i_periph_edge |=> o_fixed_66m_run[0] == $past(regs[`IDX_B4][5])
        && o_fixed_66m_run[5] == $past(regs[`IDX_B4][3]))
    else $error("66 MHz enable mapping wrong");

    a_boundary_hold:
    assert property (!i_periph_edge |=> $stable(o_pci_run) && $stable(o_free_pci_run))
    else $error("output gate changed off a boundary");

    a_ratio_source:
    assert property (##1 o_numerator == ($past(regs[`IDX_B9][`B9_SRC])
        ? $past({regs[`IDX_B7][`B7_NUM_MSB], regs[`IDX_B8]}) : ROM_NUMERATOR))
    else $error("numerator source mux wrong");

    a_reserved_fixed:
    assert property ((i_wr_valid && hit) |=> regs[`IDX_B7][7:1] == $past(regs[`IDX_B7][7:1])
        && regs[`IDX_B4][6] == $past(regs[`IDX_B4][6]))
    else $error("reserved bits changed by a write");

    a_single_offset:
    assert property ((i_cmd_valid && i_cmd[`CMD_SINGLE]) |=> ptr == $past(i_cmd[6:0]) && !bad)
    else $error("single byte offset not taken");
endmodule
`default_nettype wire

// ==== clock_synth_control_regs_bench.sv ====
// self-checking bench of the clock synthesizer control byte bank
`timescale 1ns/10ps
`default_nettype none
module clock_synth_control_regs_bench
    import clk_ctl_pkg::*;
;
    logic i_clk, i_rstn, i_host_clock_stop_n, i_power_down_n, i_pci_clock_stop_n;
    logic i_current_multiplier_select, i_pd_mode_three_state, i_host_edge, i_periph_edge;
    logic i_cmd_valid, i_wr_valid, i_rd_req, o_rd_valid;
    logic [7:0] i_cmd, i_wdata, o_rdata, o_spread_up, o_spread_down, d;
    host_pair_e o_host_pair_mode_0, o_host_pair_mode_1, o_host_pair_mode_2;
    logic [6:0] o_pci_run, o_divider;
    logic [2:0] o_free_pci_run, o_spread_sel;
    logic [5:0] o_fixed_66m_run;
    logic o_display_48m_run, o_serial_bus_48m_run, o_ref_low_strength, o_spread_center;
    logic o_display_48m_slow_edge, o_serial_bus_48m_slow_edge;
    logic [8:0] o_numerator;
    int err_total, n_tests, cyc, i;
    // expected reads: reset, after writing all ones, after writing zeros
    logic [7:0] rv [11] = '{8'h00, 8'h07, 8'h7F, 8'hC7, 8'h3F, 8'h40, 8'h35, 8'h0E, 8'h00,
        8'h00, 8'h00};
    logic [7:0] fv [11] = '{8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hBF, 8'hC5, 8'h35, 8'h0F, 8'hFF,
        8'hFF, 8'h00};
    logic [7:0] zv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h35, 8'h0E, 8'h00,
        8'h00, 8'h00};
    // host pair cases: byte 1, {stop, power-down, pd mode}, expected {pair2, pair1, pair0}
    logic [7:0] hb [8] = '{8'h07, 8'h07, 8'h27, 8'h47, 8'h07, 8'h07, 8'h47, 8'h06};
    logic [2:0] hp [8] = '{3'h6, 3'h2, 3'h2, 3'h2, 3'h4, 3'h5, 3'h4, 3'h6};
    logic [5:0] hm [8] = '{6'h00, 6'h15, 6'h05, 6'h2A, 6'h15, 6'h2A, 6'h2A, 6'h02};
    // spread amounts in hundredths of a percent per code
    logic [7:0] sd [8] = '{8'h19, 8'h32, 8'h4B, 8'h64, 8'h0D, 8'h19, 8'h25, 8'h96};
    logic [7:0] su [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h19, 8'h25, 8'h32};

    clock_synth_control_regs #(.ROM_NUMERATOR(9'h123), .ROM_DIVIDER(7'h11)) dut_u (.*);

    host_port_model host_u (.i_clk(i_clk), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid),
        .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_wr_valid(i_wr_valid),
        .o_wdata(i_wdata), .o_rd_req(i_rd_req));

    // 10 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // one comparison
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // single-byte write and read
    task automatic wrb(input logic [6:0] ofs, input logic [7:0] v);
        host_u.cmd(1'b1, ofs);
        host_u.wr(v);
    endtask

    task automatic rdc(input logic [6:0] ofs, input logic [7:0] e);
        logic [7:0] v;
        host_u.cmd(1'b1, ofs);
        host_u.rd(v);
        chk("rdata", {8'h00, e}, {8'h00, v});
    endtask

    // let pins synchronise, then one output boundary tick
    task automatic apply();
        repeat (3) @(posedge i_clk);
        i_host_edge <= 1'b1;
        i_periph_edge <= 1'b1;
        @(posedge i_clk);
        i_host_edge <= 1'b0;
        i_periph_edge <= 1'b0;
        @(negedge i_clk);
    endtask

    // main sequence
    initial
    begin
        {err_total, n_tests} = '0;
        i_rstn = 1'b0;
        {i_host_clock_stop_n, i_power_down_n, i_pci_clock_stop_n} = 3'h7;
        {i_current_multiplier_select, i_pd_mode_three_state} = 2'h0;
        {i_host_edge, i_periph_edge} = 2'h0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        host_u.cmd(1'b0, 7'h00);
        for (i = 0; i < 10; i++)
        begin
            host_u.rd(d);
            chk("block read", {8'h00, rv[i]}, {8'h00, d});
        end
        for (i = 0; i < 11; i++)
            wrb(7'(i), 8'hFF);
        for (i = 0; i < 11; i++)
            rdc(7'(i), fv[i]);
        apply();
        chk("pci run", 16'h007F, {9'h000, o_pci_run});
        chk("free pci run", 16'h0007, {13'h0000, o_free_pci_run});
        chk("48m run", 16'h0003, {14'h0000, o_display_48m_run, o_serial_bus_48m_run});
        chk("66m run", 16'h003F, {10'h000, o_fixed_66m_run});
        chk("ref low", 16'h0001, {15'h0000, o_ref_low_strength});
        chk("slow edges", 16'h0003, {14'h0000, o_display_48m_slow_edge,
            o_serial_bus_48m_slow_edge});
        chk("ratio", 16'hFFFF, {o_numerator, o_divider});
        host_u.cmd(1'b0, 7'h00);
        for (i = 0; i < 10; i++)
            host_u.wr(8'h00);
        repeat (4) @(posedge i_clk);
        chk("gate before tick", 16'h007F, {9'h000, o_pci_run});
        for (i = 0; i < 11; i++)
            rdc(7'(i), zv[i]);
        apply();
        chk("pci off", 16'h0000, {9'h000, o_pci_run});
        chk("others off", 16'h0000, {o_free_pci_run, o_display_48m_run,
            o_serial_bus_48m_run, o_fixed_66m_run, o_ref_low_strength});
        chk("rom ratio", {9'h123, 7'h11}, {o_numerator, o_divider});
        host_u.cmd(1'b0, 7'h05);
        host_u.wr(8'hFF);
        host_u.rd(d);
        chk("bad block", 16'h0000, {8'h00, d});
        for (i = 0; i < 8; i++)
        begin
            wrb(7'h01, hb[i]);
            {i_host_clock_stop_n, i_power_down_n, i_pd_mode_three_state} <= hp[i];
            apply();
            chk("host modes", {10'h000, hm[i]}, {10'h000, o_host_pair_mode_2,
                o_host_pair_mode_1, o_host_pair_mode_0});
        end
        @(posedge i_clk);
        {i_host_clock_stop_n, i_power_down_n, i_pd_mode_three_state} <= 3'h6;
        i_current_multiplier_select <= 1'b1;
        rdc(7'h01, 8'h86);
        wrb(7'h02, 8'h7F);
        wrb(7'h03, 8'hE7);
        i_pci_clock_stop_n <= 1'b0;
        apply();
        chk("pci stopped", 16'h0000, {9'h000, o_pci_run});
        chk("free stop", 16'h0003, {13'h0000, o_free_pci_run});
        @(posedge i_clk);
        i_pci_clock_stop_n <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            wrb(7'h04, {i[2], 7'h21});
            wrb(7'h05, {i[1:0], 6'h00});
            apply();
            chk("66m map", 16'h0005, {10'h000, o_fixed_66m_run});
            chk("spread sel", {13'h0000, 3'(i)}, {13'h0000, o_spread_sel});
            chk("center", {15'h0000, i[2]}, {15'h0000, o_spread_center});
            chk("spread amount", {su[i], sd[i]}, {o_spread_up, o_spread_down});
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== cs_edge_gate.sv ====
// output run gate that only changes at an output clock boundary
`timescale 1ns/10ps
`default_nettype none
module cs_edge_gate #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // boundary tick and requested run state
    input wire logic i_boundary,
    input wire logic [W-1:0] i_want,
    output var logic [W-1:0] o_run
);
    // requested state is taken only at a boundary, never mid pulse
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_run <= RST;
        else if (i_boundary)
            o_run <= i_want;
    end
endmodule
`default_nettype wire

// ==== cs_sync2.sv ====
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module cs_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // levels
    input wire logic [W-1:0] i_d,
    output var logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta <= RST;
            o_q <= RST;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== host_port_model.sv ====
// management host model driving the byte access port of the control bank
`timescale 1ns/10ps
`default_nettype none
module host_port_model
(
    // clock
    input wire logic i_clk,
    // read answer from the bank
    input wire logic [7:0] i_rdata,
    input wire logic i_rd_valid,
    // requests to the bank
    output var logic o_cmd_valid,
    output var logic [7:0] o_cmd,
    output var logic o_wr_valid,
    output var logic [7:0] o_wdata,
    output var logic o_rd_req
);
    // idle levels at time zero
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd = 8'h00;
        o_wr_valid = 1'b0;
        o_wdata = 8'h00;
        o_rd_req = 1'b0;
    end

    // command byte: top bit picks single or block, low bits the offset
    task automatic cmd(input logic single, input logic [6:0] ofs);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd <= {single, ofs};
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd <= ~{single, ofs}; // released lines show garbage
    endtask

    // one data byte at the pointer
    task automatic wr(input logic [7:0] d);
        @(posedge i_clk);
        o_wr_valid <= 1'b1;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        o_wdata <= ~d;
    endtask

    // one read; the answer must come exactly one cycle after it is taken
    task automatic rd(output logic [7:0] d);
        @(posedge i_clk);
        o_rd_req <= 1'b1;
        @(posedge i_clk);
        o_rd_req <= 1'b0;
        @(posedge i_clk);
        d = (i_rd_valid === 1'b1) ? i_rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire
